// file: src/lcc_charger_top.sv
module lcc_charger_top #(
  parameter int TICK_CYCLES = lcc_pkg::TICK_CYCLES,
  parameter int DEGLITCH_CYCLES = lcc_pkg::DEGLITCH_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host pins
  input wire logic input_limit_select_hi,
  input wire logic input_limit_select_lo,
  input wire logic charger_enable_in,
  output logic charge_status_n_o,
  output logic charge_status_n_oe,
  // analog comparator results
  input wire logic dc_undervoltage,
  input wire logic dc_below_battery,
  input wire logic input_overvoltage_level,
  input wire logic battery_below_prequal,
  input wire logic battery_below_restart,
  input wire logic charge_at_topoff,
  input wire logic charge_above_half,
  input wire logic charge_above_fifth,
  input wire logic cv_phase,
  input wire logic die_temp_limiting,
  input wire logic [10:0] sys_load_ma,
  input wire logic [10:0] charge_max_ma,
  // power path and charger commands
  output logic dc_to_system_rail_on,
  output logic load_switch_closed,
  output logic [10:0] input_limit_ma,
  output logic charger_on,
  output logic [10:0] charge_current_cmd_ma
);
  import lcc_pkg::*;

  lcc_state_e state_reg, state_next;
  logic [TMR_W-1:0] tmr_reg, tmr_next;
  logic [TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
  logic blink_reg, blink_next;
  logic permit_reg, permit_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic oe_reg, oe_next, dcsys_reg, dcsys_next, lsw_reg, lsw_next, chg_reg, chg_next;
  logic [10:0] ilim_reg, ilim_next, cmd_reg, cmd_next;
  logic [1:0] code_q, step;
  logic [10:0] headroom, target;
  logic dc_valid, suspended, run, tick, entry, reduced_by_load, charging_next;

  lcc_deglitch #(.W(2), .CYCLES(DEGLITCH_CYCLES), .RESET_VAL(DG_RESET_CODE)) u_limit_filter (
    .clk(pclk),
    .rst_n(presetn),
    .raw({input_limit_select_hi, input_limit_select_lo}),
    .q(code_q)
  );

  // input qualification and limit decode
  always_comb begin
    dc_valid = !dc_undervoltage && !dc_below_battery;
    suspended = (code_q == CODE_SUSPEND);
    unique case (code_q)
      CODE_1000MA: ilim_next = ILIM_1000MA;
      CODE_475MA: ilim_next = ILIM_475MA;
      CODE_95MA: ilim_next = ILIM_95MA;
      CODE_SUSPEND: ilim_next = '0;
    endcase
    // overvoltage drops the input path but the battery still feeds the rail
    dcsys_next = dc_valid && !suspended && !input_overvoltage_level;
    lsw_next = !dcsys_next;
    run = dcsys_next && charger_enable_in && permit_reg;
  end

  // charger sequence; a stop from any state wins over everything
  always_comb begin
    state_next = state_reg;
    if (!run) begin
      state_next = CHG_IDLE;
    end else begin
      unique case (state_reg)
        CHG_IDLE: state_next = battery_below_prequal ? CHG_PREQUAL : CHG_FAST;
        CHG_PREQUAL: begin
          if (tmr_reg >= PREQUAL_LIM) begin
            state_next = CHG_FAULT;
          end else if (!battery_below_prequal) begin
            state_next = CHG_FAST;
          end
        end
        CHG_FAST: begin
          if (tmr_reg >= FAST_LIM) begin
            state_next = CHG_FAULT;
          end else if (cv_phase && charge_at_topoff) begin
            state_next = CHG_TOPOFF;
          end
        end
        CHG_TOPOFF: begin
          if (tmr_reg >= TOPOFF_LIM) begin
            state_next = CHG_DONE;
          end
        end
        CHG_DONE: begin
          if (battery_below_restart) begin
            state_next = battery_below_prequal ? CHG_PREQUAL : CHG_FAST;
          end
        end
        CHG_FAULT: state_next = CHG_FAULT;
        default: state_next = CHG_IDLE;
      endcase
    end
  end

  // current budget: system load is served first, the charger gets what is left
  always_comb begin
    headroom = (ilim_reg > sys_load_ma) ? (ilim_reg - sys_load_ma) : '0;
    target = (state_next == CHG_PREQUAL) ? 11'(charge_max_ma / PREQUAL_DIV) : charge_max_ma;
    reduced_by_load = (target > headroom);
    charging_next = (state_next == CHG_PREQUAL) || (state_next == CHG_FAST) || (state_next == CHG_TOPOFF);
    chg_next = charging_next;
    cmd_next = !charging_next ? '0 : (reduced_by_load ? headroom : target);
  end

  // time base and fault timer; the prescaler also restarts so every interval starts at entry
  always_comb begin
    entry = (state_next != state_reg);
    tick = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));
    step = STEP_FULL;
    if (state_reg == CHG_FAST && !cv_phase) begin
      if (!charge_above_fifth) begin
        step = STEP_PAUSE;
      end else if (!charge_above_half || die_temp_limiting || reduced_by_load) begin
        step = STEP_HALF;
      end
    end
    tick_cnt_next = (entry || tick) ? '0 : tick_cnt_reg + TICK_W'(1);
    tmr_next = tmr_reg;
    blink_next = blink_reg;
    if (entry) begin
      tmr_next = '0;
      blink_next = 1'b1;
    end else if (tick) begin
      if (state_reg == CHG_PREQUAL || state_reg == CHG_FAST || state_reg == CHG_TOPOFF) begin
        tmr_next = tmr_reg + TMR_W'(step);
      end
      blink_next = !blink_reg;
    end
    // low in prequal and fast, blink in fault, released elsewhere
    oe_next = (state_next == CHG_PREQUAL) || (state_next == CHG_FAST) ||
              ((state_next == CHG_FAULT) && blink_next);
  end

  // apb slave: zero wait states, read data captured in the setup cycle
  always_comb begin
    permit_next = permit_reg;
    pready_next = psel && !penable;
    pslverr_next = 1'b0;
    prdata_next = '0;
    if (psel && penable && pready_reg && pwrite && paddr == ADDR_CTRL) begin
      permit_next = pwdata[CTRL_PERMIT_BIT];
    end
    if (psel && !penable) begin
      unique case (paddr)
        ADDR_CTRL: prdata_next[CTRL_PERMIT_BIT] = permit_reg;
        ADDR_STATUS: begin
          prdata_next[ST_STATE_LSB +: 6] = state_reg;
          prdata_next[ST_CODE_LSB +: 2] = code_q;
          prdata_next[ST_VALID_BIT] = dc_valid;
          prdata_next[ST_OVLO_BIT] = input_overvoltage_level;
          prdata_next[ST_LOADSW_BIT] = lsw_reg;
          prdata_next[ST_REDUCED_BIT] = reduced_by_load;
        end
        ADDR_TIMER: prdata_next[TMR_W-1:0] = tmr_reg;
        default: pslverr_next = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= CHG_IDLE;
      tmr_reg <= '0;
      tick_cnt_reg <= '0;
      blink_reg <= 1'b0;
      permit_reg <= CTRL_PERMIT_RESET;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
      oe_reg <= 1'b0;
      dcsys_reg <= 1'b0;
      lsw_reg <= 1'b1;
      chg_reg <= 1'b0;
      ilim_reg <= '0;
      cmd_reg <= '0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      tick_cnt_reg <= tick_cnt_next;
      blink_reg <= blink_next;
      permit_reg <= permit_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
      oe_reg <= oe_next;
      dcsys_reg <= dcsys_next;
      lsw_reg <= lsw_next;
      chg_reg <= chg_next;
      ilim_reg <= ilim_next;
      cmd_reg <= cmd_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign charge_status_n_o = 1'b0; // open drain only ever pulls low
  assign charge_status_n_oe = oe_reg;
  assign dc_to_system_rail_on = dcsys_reg;
  assign load_switch_closed = lsw_reg;
  assign input_limit_ma = ilim_reg;
  assign charger_on = chg_reg;
  assign charge_current_cmd_ma = cmd_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_suspend_opens: assert property (code_q == CODE_SUSPEND
    |=> !dc_to_system_rail_on && input_limit_ma == 11'h000) else $error("suspend code left input connected");
  a_limit_full: assert property (code_q == CODE_1000MA |=> input_limit_ma == ILIM_1000MA)
    else $error("code 00 did not give 1000 mA");
  a_invalid_cut: assert property ((dc_undervoltage || dc_below_battery) |=> !dc_to_system_rail_on)
    else $error("invalid input stayed connected");
  a_ovlo_cut: assert property (input_overvoltage_level |=> !dc_to_system_rail_on && load_switch_closed)
    else $error("overvoltage did not move rail to battery");
  a_switch_excl: assert property (dc_to_system_rail_on != load_switch_closed)
    else $error("load switch and input path disagree");
  a_stop_idle: assert property (!charger_enable_in |=> state_reg == CHG_IDLE && !charger_on)
    else $error("enable low did not stop the charger");
  // no start unless the input is usable and the host has enabled charging
  a_start_gate: assert property (state_reg == CHG_IDLE && !(dc_valid && !suspended && charger_enable_in)
    |=> state_reg == CHG_IDLE) else $error("charger left idle without a valid start");
  a_prequal_cur: assert property (state_reg == CHG_PREQUAL
    |-> charge_current_cmd_ma <= $past(charge_max_ma) / PREQUAL_DIV) else $error("prequal current above a tenth");
  a_budget_fit: assert property (charger_on && $past(ilim_reg) >= $past(sys_load_ma)
    |-> charge_current_cmd_ma + $past(sys_load_ma) <= $past(ilim_reg)) else $error("input budget exceeded");
  a_status_low: assert property ((state_reg == CHG_PREQUAL || state_reg == CHG_FAST) |-> charge_status_n_oe)
    else $error("status not pulled low while charging");
  a_status_free: assert property (state_reg inside {CHG_IDLE, CHG_TOPOFF, CHG_DONE}
    |-> !charge_status_n_oe) else $error("status driven while idle or finished");
  a_fault_latch: assert property (state_reg == CHG_FAULT && run |=> state_reg == CHG_FAULT)
    else $error("fault released while running");
  a_prequal_tmo: assert property (state_reg == CHG_PREQUAL && tmr_reg >= PREQUAL_LIM && run
    |=> state_reg == CHG_FAULT) else $error("prequal timeout missed");
  a_fast_tmo: assert property (state_reg == CHG_FAST && tmr_reg >= FAST_LIM && run |=> state_reg == CHG_FAULT)
    else $error("fast charge timeout missed");
  a_entry_clear: assert property (state_reg != $past(state_reg) |-> tmr_reg == '0 && tick_cnt_reg == '0)
    else $error("timers not restarted on entry");
  a_pause_hold: assert property (state_reg == CHG_FAST && !cv_phase && !charge_above_fifth
    && state_next == CHG_FAST |=> tmr_reg == $past(tmr_reg)) else $error("fast timer ran while paused");

  c_prequal_fast: cover property (state_reg == CHG_PREQUAL ##1 state_reg == CHG_FAST);
  c_topoff_done: cover property (state_reg == CHG_TOPOFF ##1 state_reg == CHG_DONE);
  c_fault_blink: cover property (state_reg == CHG_FAULT && charge_status_n_oe ##1 !charge_status_n_oe);
  c_restart: cover property (state_reg == CHG_DONE ##1 state_reg == CHG_FAST);
endmodule // lcc_charger_top

// file: shared/lcc_pkg.sv
package lcc_pkg;
  // clock and time base
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_MS = 250; // time base period, half of one 2Hz blink period
  localparam int TICK_CYCLES = TICK_MS * (CLK_HZ / 1000);
  localparam int TICKS_PER_MIN = 60_000 / TICK_MS;
  localparam int TICK_W = 23;

  // charge timers count half ticks so the fast timer can run at half rate
  localparam int TMR_W = 20;
  localparam int PREQUAL_MIN = 33;
  localparam int FAST_MIN = 660;
  localparam int TOPOFF_MIN = 33;
  localparam logic [TMR_W-1:0] PREQUAL_LIM = TMR_W'(2 * PREQUAL_MIN * TICKS_PER_MIN);
  localparam logic [TMR_W-1:0] FAST_LIM = TMR_W'(2 * FAST_MIN * TICKS_PER_MIN);
  localparam logic [TMR_W-1:0] TOPOFF_LIM = TMR_W'(2 * TOPOFF_MIN * TICKS_PER_MIN);
  localparam logic [1:0] STEP_FULL = 2'h2;
  localparam logic [1:0] STEP_HALF = 2'h1;
  localparam logic [1:0] STEP_PAUSE = 2'h0;

  // limit select deglitch
  localparam int DEGLITCH_US = 100;
  localparam int DEGLITCH_CYCLES = DEGLITCH_US * (CLK_HZ / 1_000_000);
  localparam int DG_W = 12;
  localparam logic [1:0] DG_RESET_CODE = 2'h3; // start suspended until a code is stable

  // input limit codes and currents in mA
  localparam logic [1:0] CODE_1000MA = 2'h0;
  localparam logic [1:0] CODE_475MA = 2'h1;
  localparam logic [1:0] CODE_95MA = 2'h2;
  localparam logic [1:0] CODE_SUSPEND = 2'h3;
  localparam logic [10:0] ILIM_1000MA = 11'h3E8;
  localparam logic [10:0] ILIM_475MA = 11'h1DB;
  localparam logic [10:0] ILIM_95MA = 11'h05F;
  localparam logic [10:0] PREQUAL_DIV = 11'h00A; // prequal current is a tenth of maximum

  // register map
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_TIMER = 12'h008;
  localparam int CTRL_PERMIT_BIT = 0;
  localparam logic CTRL_PERMIT_RESET = 1'b1;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_CODE_LSB = 6;
  localparam int ST_VALID_BIT = 8;
  localparam int ST_OVLO_BIT = 9;
  localparam int ST_LOADSW_BIT = 10;
  localparam int ST_REDUCED_BIT = 11;

  typedef enum logic [5:0] {
    CHG_IDLE = 6'h01,
    CHG_PREQUAL = 6'h02,
    CHG_FAST = 6'h04,
    CHG_TOPOFF = 6'h08,
    CHG_DONE = 6'h10,
    CHG_FAULT = 6'h20
  } lcc_state_e;
endpackage

// file: src/lcc_deglitch.sv
module lcc_deglitch #(
  parameter int W = 2,
  parameter int CYCLES = 4,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // raw and filtered code
  input wire logic [W-1:0] raw,
  output logic [W-1:0] q
);
  import lcc_pkg::*;

  logic [W-1:0] cand_reg, cand_next, q_reg, q_next;
  logic [DG_W-1:0] cnt_reg, cnt_next;

  // the whole code must sit still for the window, so a carry between bits never shows
  always_comb begin
    cand_next = raw;
    cnt_next = cnt_reg;
    q_next = q_reg;
    if (raw != cand_reg) begin
      cnt_next = '0;
    end else if (cnt_reg == DG_W'(CYCLES - 1)) begin
      q_next = cand_reg;
    end else begin
      cnt_next = cnt_reg + DG_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cand_reg <= RESET_VAL;
      cnt_reg <= '0;
      q_reg <= RESET_VAL;
    end else begin
      cand_reg <= cand_next;
      cnt_reg <= cnt_next;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;

  a_glitch_blocked: assert property (@(posedge clk) disable iff (!rst_n)
    (raw != cand_reg) |=> $stable(q_reg)) else $error("filtered code moved on a raw change");
endmodule // lcc_deglitch

// file: testbench/lcc_host_model.sv
module lcc_host_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench request and status pin from the charger
  input wire logic charge_req,
  input wire logic status_o,
  input wire logic status_oe,
  // enable pin and resolved status level
  output logic charger_enable_in,
  output logic status_level
);
  timeunit 1ns;
  timeprecision 1ps;

  // enable pin is held low in reset so no charge starts before the host is up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charger_enable_in <= 1'b0;
    end else begin
      charger_enable_in <= charge_req;
    end
  end

  // pull-up on the open-drain line: released reads high
  assign status_level = status_oe ? status_o : 1'b1;
endmodule // lcc_host_model

// file: testbench/tb_lcc_charger_top.sv
module tb_lcc_charger_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lcc_pkg::*;

  // small prescaler and deglitch counts keep the run short
  localparam int TK = 4;
  localparam int DG = 3;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, bsamp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, t0;
  logic sel_hi, sel_lo, en, st_o, st_oe, st_lvl, req;
  logic uv, blw, ov, bpre, brst, ctop, chalf, cfifth, cv, temp;
  logic [10:0] load, cmax, ilim, cmd;
  logic rail, lsw, chg_on;
  logic [3:0] rc [5] = '{4'hC, 4'h4, 4'h0, 4'h2, 4'hD};
  int dexp [5] = '{20, 10, 0, 20, 10};
  int err_count, total_checks;
  int cyc = 0;

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;

  lcc_charger_top #(.TICK_CYCLES(TK), .DEGLITCH_CYCLES(DG)) u_lcc_charger_top (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .input_limit_select_hi(sel_hi), .input_limit_select_lo(sel_lo), .charger_enable_in(en),
    .charge_status_n_o(st_o), .charge_status_n_oe(st_oe), .dc_undervoltage(uv), .dc_below_battery(blw),
    .input_overvoltage_level(ov), .battery_below_prequal(bpre), .battery_below_restart(brst),
    .charge_at_topoff(ctop), .charge_above_half(chalf), .charge_above_fifth(cfifth), .cv_phase(cv),
    .die_temp_limiting(temp), .sys_load_ma(load), .charge_max_ma(cmax), .dc_to_system_rail_on(rail),
    .load_switch_closed(lsw), .input_limit_ma(ilim), .charger_on(chg_on), .charge_current_cmd_ma(cmd));

  lcc_host_model u_lcc_host_model (
    .pclk(pclk), .presetn(presetn), .charge_req(req), .status_o(st_o), .status_oe(st_oe),
    .charger_enable_in(en), .status_level(st_lvl));

  // verdict and end of run
  task final_report();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // one apb transfer; waits for pready under a bound
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      chk("pready", 0, 1);
      final_report();
    end
  endtask

  task step(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task st_is(input lcc_state_e s);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("state", {26'h0, rd[5:0]}, {26'h0, s});
  endtask

  // polls the state by reads; a hang is cut after a fixed number of polls
  task wait_state(input lcc_state_e s);
    int n;
    n = 0;
    apb(1'b0, ADDR_STATUS, 32'h0);
    while (rd[5:0] !== s && n < 15000) begin
      n++;
      apb(1'b0, ADDR_STATUS, 32'h0);
    end
    chk("state_wait", {26'h0, rd[5:0]}, {26'h0, s});
    if (n >= 15000) final_report();
  endtask

  function automatic logic [10:0] lim_of(input int c);
    case (c)
      0: return 11'h3E8;
      1: return 11'h1DB;
      2: return 11'h05F;
      default: return 11'h000;
    endcase
  endfunction

  // system load first, charger gets what is left of the 1000 mA limit
  function automatic logic [10:0] share(input logic [10:0] ld, input logic [10:0] mx);
    if (ld >= 11'h3E8) return 11'h000;
    return (11'h3E8 - ld < mx) ? 11'h3E8 - ld : mx;
  endfunction

  initial begin
    {psel, penable, pwrite, presetn, sel_hi, sel_lo, req, uv, blw, ov} = '0;
    {bpre, brst, ctop, chalf, cfifth, cv, temp} = 7'h0C;
    paddr = 12'h000;
    pwdata = 32'h0;
    load = 11'h064;
    cmax = 11'h1F4;
    err_count = 0;
    total_checks = 0;
    void'($urandom(32'h17746434));
    step(20);
    chk("switch_rst", lsw, 1);
    chk("limit_rst", ilim, 0);
    chk("status_rst", st_oe, 0);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl_rst", rd, 32'h1);
    apb(1'b0, 12'h00C, 32'h0);
    chk("slverr", err, 1);
    chk("unmapped", rd, 0);
    // every select code, enable low so the charger stays idle
    for (int c = 0; c < 4; c++) begin
      @(posedge pclk);
      sel_hi <= c[1];
      sel_lo <= c[0];
      step(DG + 6);
      chk("limit", ilim, lim_of(c));
      chk("rail_code", rail, c != 3);
    end
    @(posedge pclk);
    {sel_hi, sel_lo} <= 2'h0;
    step(DG + 6);
    // one-cycle transient through code 11 must not suspend
    @(posedge pclk);
    {sel_hi, sel_lo} <= 2'h3;
    @(posedge pclk);
    {sel_hi, sel_lo} <= 2'h0;
    step(DG + 1);
    chk("limit_glitch", ilim, 11'h3E8);
    chk("rail_glitch", rail, 1);
    st_is(CHG_IDLE);
    // undervoltage, below battery, overvoltage, valid
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      {uv, blw, ov} <= {i == 0, i == 1, i == 2};
      step(3);
      chk("rail", rail, i == 3);
      chk("switch", lsw, i != 3);
    end
    @(posedge pclk);
    bpre <= 1'b1;
    req <= 1'b1;
    step(4);
    st_is(CHG_PREQUAL);
    chk("cmd_pre", cmd, 11'h032);
    chk("status_pin", st_lvl, 0);
    @(posedge pclk);
    bpre <= 1'b0;
    step(3);
    st_is(CHG_FAST);
    chk("cmd_fast", cmd, 11'h1F4);
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      load <= (i == 0) ? 11'h3E8 : 11'($urandom_range(1100));
      cmax <= 11'($urandom_range(1000, 200));
      step(3);
      chk("cmd_share", cmd, share(load, cmax));
    end
    @(posedge pclk);
    load <= 11'h064;
    cmax <= 11'h1F4;
    // timer advance over 40 cycles between read captures
    for (int i = 0; i < 5; i++) begin
      @(posedge pclk);
      {chalf, cfifth, cv, temp} <= rc[i];
      step(2);
      apb(1'b0, ADDR_TIMER, 32'h0);
      t0 = rd;
      repeat (37) @(posedge pclk);
      apb(1'b0, ADDR_TIMER, 32'h0);
      chk("timer_rate", rd - t0, dexp[i]);
    end
    @(posedge pclk);
    {chalf, cfifth, cv, temp} <= 4'hC;
    apb(1'b1, ADDR_CTRL, 32'h0);
    step(2);
    st_is(CHG_IDLE);
    chk("cmd_off", cmd, 0);
    chk("status_off", st_oe, 0);
    apb(1'b1, ADDR_CTRL, 32'h1);
    step(2);
    st_is(CHG_FAST);
    @(posedge pclk);
    req <= 1'b0;
    step(3);
    st_is(CHG_IDLE);
    @(posedge pclk);
    req <= 1'b1;
    step(3);
    @(posedge pclk);
    ctop <= 1'b1;
    cv <= 1'b1;
    step(3);
    st_is(CHG_TOPOFF);
    chk("status_top", st_oe, 0);
    chk("on_top", chg_on, 1);
    wait_state(CHG_DONE);
    chk("on_done", chg_on, 0);
    chk("cmd_done", cmd, 0);
    @(posedge pclk);
    brst <= 1'b1;
    ctop <= 1'b0;
    cv <= 1'b0;
    step(3);
    st_is(CHG_FAST);
    apb(1'b0, ADDR_TIMER, 32'h0);
    chk("timer_fresh", rd[19:0] < 8, 1);
    @(posedge pclk);
    brst <= 1'b0;
    req <= 1'b0;
    step(3);
    // prequal timeout: 15840 half-ticks at two per tick of TK cycles
    @(posedge pclk);
    bpre <= 1'b1;
    req <= 1'b1;
    t0 = cyc;
    wait_state(CHG_FAULT);
    chk("pq_time", (cyc - t0 >= 31680) && (cyc - t0 <= 31700), 1);
    step(1);
    bsamp = st_oe;
    step(TK);
    chk("blink", bsamp ^ st_oe, 1);
    @(posedge pclk);
    bpre <= 1'b0;
    step(6);
    st_is(CHG_FAULT);
    @(posedge pclk);
    {sel_hi, sel_lo} <= 2'h3;
    step(DG + 6);
    st_is(CHG_IDLE);
    chk("status_idle", st_oe, 0);
    final_report();
  end
endmodule // tb_lcc_charger_top
